/* hw/clmne_params.svh */
// constants for the code lookup, multiply and idle execution block
`ifndef CLMNE_PARAMS_SVH
`define CLMNE_PARAMS_SVH

// ************************************************************
// opcodes
// ************************************************************
`define CLMNE_OP_IDLE        8'h00
`define CLMNE_OP_LOAD_PC     8'h83
`define CLMNE_OP_LOAD_DP     8'h93
`define CLMNE_OP_PRODUCT     8'hA4

// ************************************************************
// machine cycle counts and timing
// ************************************************************
`define CLMNE_CYC_IDLE       3'd1
`define CLMNE_CYC_LOAD       3'd2
`define CLMNE_CYC_PRODUCT    3'd4
`define CLMNE_CLKS_PER_MC    4'd1

// ************************************************************
// reset values and byte limit
// ************************************************************
`define CLMNE_RST_BYTE       8'h00
`define CLMNE_RST_WORD       16'h0000
`define CLMNE_BYTE_MAX       16'h00FF

`endif

/* hw/clmne_pkg.sv */
// types for the code lookup, multiply and idle execution block
package clmne_pkg;

  typedef enum logic [1:0] {
    CLMNE_K_NONE,
    CLMNE_K_IDLE,
    CLMNE_K_LOAD,
    CLMNE_K_PRODUCT
  } clmne_kind_e;

  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  aux;
    logic [15:0] pc;
    logic [15:0] data_pointer;
    logic        carry;
    logic        product_exceeds_byte_flag;
  } clmne_arch_s;

  typedef struct packed {
    clmne_kind_e kind;
    logic        use_pc;
    logic [2:0]  cycles;
  } clmne_decode_s;

endpackage

/* hw/clmne_decode.sv */
// opcode decoder for the three handled instructions
`timescale 1ns/10ps
`include "clmne_params.svh"
module clmne_decode (
  input  wire logic [7:0]            opcode_i,
  output clmne_pkg::clmne_decode_s   dec_o
);

  // ************************************************************
  // decode
  // ************************************************************
  always_comb begin
    dec_o        = '{kind: clmne_pkg::CLMNE_K_NONE, use_pc: 1'b0, cycles: 3'd0};
    unique case (opcode_i)
      `CLMNE_OP_LOAD_PC: begin
        dec_o = '{kind: clmne_pkg::CLMNE_K_LOAD, use_pc: 1'b1,
                  cycles: `CLMNE_CYC_LOAD};
      end
      `CLMNE_OP_LOAD_DP: begin
        dec_o = '{kind: clmne_pkg::CLMNE_K_LOAD, use_pc: 1'b0,
                  cycles: `CLMNE_CYC_LOAD};
      end
      `CLMNE_OP_PRODUCT: begin
        dec_o = '{kind: clmne_pkg::CLMNE_K_PRODUCT, use_pc: 1'b0,
                  cycles: `CLMNE_CYC_PRODUCT};
      end
      `CLMNE_OP_IDLE: begin
        dec_o = '{kind: clmne_pkg::CLMNE_K_IDLE, use_pc: 1'b0,
                  cycles: `CLMNE_CYC_IDLE};
      end
      default: begin
        dec_o = '{kind: clmne_pkg::CLMNE_K_NONE, use_pc: 1'b0, cycles: 3'd0};
      end
    endcase
  end

endmodule

/* hw/clmne_mult.sv */
// combinational 8x8 unsigned product with one exceeds flag output
`timescale 1ns/10ps
`include "clmne_params.svh"
module clmne_mult (
  input  wire logic [7:0]  a_i,
  input  wire logic [7:0]  b_i,
  output logic      [15:0] product_o,
  output logic             exceeds_o
);

  // ************************************************************
  // product
  // ************************************************************
  always_comb begin
    product_o = 16'(a_i) * 16'(b_i);
    exceeds_o = (product_o > `CLMNE_BYTE_MAX);
  end

endmodule

/* hw/clmne_exec.sv */
// execution unit for code table load, unsigned byte product and idle instruction
`timescale 1ns/10ps
`include "clmne_params.svh"
// ************************************************************
// Overview of operation
// - code_table_load reads one program byte at accumulator plus base into the accumulator.
// - with pc base the pc is first advanced past the opcode; data_pointer base is untouched.
// - the table address is a full 16-bit sum so low byte carry reaches the upper bits.
// - code_table_load changes no status flag.
// - opcode 8'h83 selects the pc based load, one byte long, two machine cycles.
// - unsigned_byte_product puts the low product byte in acc and the high byte in aux.
// - product_exceeds_byte_flag is set when the product is above 255, else cleared.
// - unsigned_byte_product always clears carry.
// - opcode 8'hA4 selects the product, one byte long, four machine cycles.
// - idle_instruction only advances the pc.
// - opcode 8'h00 is idle_instruction, one byte and one machine cycle.
// ************************************************************
module clmne_exec #(
  parameter int unsigned MC_CLKS = 1
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     issue_valid_i,
  input  wire logic [7:0]               issue_opcode_i,
  input  wire clmne_pkg::clmne_arch_s   arch_i,
  output logic                          issue_ready_o,
  output logic                          unknown_op_o,
  output logic                          code_rd_req_o,
  output logic      [15:0]              code_rd_addr_o,
  input  wire logic [7:0]               code_rd_data_i,
  output clmne_pkg::clmne_arch_s        arch_o,
  output logic                          arch_we_o,
  output logic                          busy_o
);

  typedef enum logic [1:0] {
    CLMNE_ST_IDLE,
    CLMNE_ST_RUN,
    CLMNE_ST_DONE
  } clmne_state_e;

  clmne_pkg::clmne_decode_s  dec;
  logic [15:0]               product;
  logic                      exceeds;

  clmne_state_e              state_q,   state_d;
  clmne_pkg::clmne_kind_e    kind_q,    kind_d;
  logic [2:0]                mc_left_q, mc_left_d;
  logic [7:0]                tick_q,    tick_d;
  clmne_pkg::clmne_arch_s    work_q,    work_d;
  clmne_pkg::clmne_arch_s    out_q,     out_d;
  logic                      we_q,      we_d;
  logic                      rd_q,      rd_d;
  logic [15:0]               addr_q,    addr_d;

  // ************************************************************
  // helpers
  // ************************************************************
  // zero extension keeps acc unsigned; full 16-bit sum wraps only at 64k
  function automatic logic [15:0] table_addr(input logic [7:0] acc, input logic [15:0] base);
    table_addr = 16'(base + {8'h00, acc});
  endfunction

  function automatic logic [15:0] pc_next(input logic [15:0] pc);
    pc_next = 16'(pc + 16'h0001);
  endfunction

  clmne_decode u_decode (
    .opcode_i (issue_opcode_i),
    .dec_o    (dec)
  );

  clmne_mult u_mult (
    .a_i       (work_q.acc),
    .b_i       (work_q.aux),
    .product_o (product),
    .exceeds_o (exceeds)
  );

  // ************************************************************
  // handshake
  // ************************************************************
  always_comb begin
    issue_ready_o = (state_q == CLMNE_ST_IDLE);
    unknown_op_o  = issue_valid_i && issue_ready_o &&
                    (dec.kind == clmne_pkg::CLMNE_K_NONE);
    busy_o        = (state_q != CLMNE_ST_IDLE);
  end

  // ************************************************************
  // sequencing and datapath next state
  // ************************************************************
  always_comb begin
    state_d   = state_q;
    kind_d    = kind_q;
    mc_left_d = mc_left_q;
    tick_d    = tick_q;
    work_d    = work_q;
    out_d     = out_q;
    we_d      = 1'b0;
    rd_d      = 1'b0;
    addr_d    = addr_q;
    unique case (state_q)
      CLMNE_ST_IDLE: begin
        if (issue_valid_i && (dec.kind != clmne_pkg::CLMNE_K_NONE)) begin
          kind_d    = dec.kind;
          mc_left_d = dec.cycles;
          tick_d    = 8'(MC_CLKS - 1);
          work_d    = arch_i;
          // every handled opcode is one byte long
          work_d.pc = pc_next(arch_i.pc);
          state_d   = CLMNE_ST_RUN;
          if (dec.kind == clmne_pkg::CLMNE_K_LOAD) begin
            // pc base uses the advanced pc, data_pointer is only read
            addr_d = dec.use_pc ? table_addr(arch_i.acc, pc_next(arch_i.pc))
                                : table_addr(arch_i.acc, arch_i.data_pointer);
            rd_d   = 1'b1;
          end
        end
      end
      CLMNE_ST_RUN: begin
        if (tick_q != 8'h00) begin
          tick_d = 8'(tick_q - 8'h01);
        end else begin
          tick_d    = 8'(MC_CLKS - 1);
          mc_left_d = 3'(mc_left_q - 3'd1);
          if (mc_left_q == 3'd1) begin
            state_d = CLMNE_ST_DONE;
            out_d   = work_q;
            we_d    = 1'b1;
            unique case (kind_q)
              clmne_pkg::CLMNE_K_LOAD: begin
                // flags pass through from the snapshot untouched
                out_d.acc = code_rd_data_i;
              end
              clmne_pkg::CLMNE_K_PRODUCT: begin
                out_d.acc                       = product[7:0];
                out_d.aux                       = product[15:8];
                out_d.product_exceeds_byte_flag = exceeds;
                out_d.carry                     = 1'b0;
              end
              default: begin
                out_d = work_q;
              end
            endcase
          end
        end
      end
      CLMNE_ST_DONE: begin
        state_d = CLMNE_ST_IDLE;
      end
      default: begin
        state_d = CLMNE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_q   <= CLMNE_ST_IDLE;
      kind_q    <= clmne_pkg::CLMNE_K_NONE;
      mc_left_q <= 3'd0;
      tick_q    <= 8'h00;
      work_q    <= '0;
      out_q     <= '0;
      we_q      <= 1'b0;
      rd_q      <= 1'b0;
      addr_q    <= `CLMNE_RST_WORD;
    end else begin
      state_q   <= state_d;
      kind_q    <= kind_d;
      mc_left_q <= mc_left_d;
      tick_q    <= tick_d;
      work_q    <= work_d;
      out_q     <= out_d;
      we_q      <= we_d;
      rd_q      <= rd_d;
      addr_q    <= addr_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb begin
    arch_o         = out_q;
    arch_we_o      = we_q;
    code_rd_req_o  = rd_q;
    code_rd_addr_o = addr_q;
  end

endmodule

/* verif/clmne_exec_checker.sv */
// assertion checker for the execution block
`timescale 1ns/10ps
module clmne_exec_checker #(
  parameter int unsigned MC_CLKS = 1
) (
  input wire logic                   ref_clk_i,
  input wire logic                   nrst_i,
  input wire logic                   issue_valid_i,
  input wire logic [7:0]             issue_opcode_i,
  input wire clmne_pkg::clmne_arch_s arch_i,
  input wire logic                   issue_ready_o,
  input wire logic                   unknown_op_o,
  input wire logic                   code_rd_req_o,
  input wire logic [15:0]            code_rd_addr_o,
  input wire logic [7:0]             code_rd_data_i,
  input wire clmne_pkg::clmne_arch_s arch_o,
  input wire logic                   arch_we_o,
  input wire logic                   busy_o
);
  // ****
  // delays assume one clock per machine cycle
  // ****
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic                   tk;
  logic [7:0]             op_q;
  logic [15:0]            prod_q;
  clmne_pkg::clmne_arch_s snap_q;
  assign tk = issue_valid_i && issue_ready_o;
  // snapshot holds pc already advanced
  always_ff @(posedge ref_clk_i) begin
    if (tk) begin
      op_q      <= issue_opcode_i;
      prod_q    <= {8'h00, arch_i.acc} * {8'h00, arch_i.aux};
      snap_q    <= arch_i;
      snap_q.pc <= arch_i.pc + 16'h0001;
    end
  end
  property p_idle;
    tk && issue_opcode_i == 8'h00 |-> ##2 arch_we_o && arch_o == snap_q;
  endproperty
  a_idle: assert property (p_idle) else $error("idle result wrong");
  property p_load_lat;
    tk && (issue_opcode_i == 8'h83 || issue_opcode_i == 8'h93) |=> !arch_we_o [*2] ##1 arch_we_o;
  endproperty
  a_load_lat: assert property (p_load_lat) else $error("load timing wrong");
  property p_req;
    tk && issue_opcode_i inside {8'h83, 8'h93} |=> code_rd_req_o && code_rd_addr_o ==
      (op_q == 8'h83 ? snap_q.pc : snap_q.data_pointer) + {8'h00, snap_q.acc};
  endproperty
  a_req: assert property (p_req) else $error("table address wrong");
  // one read per load, never a held request
  property p_req_pulse;
    code_rd_req_o |=> !code_rd_req_o;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("read request too long");
  property p_no_req;
    tk && issue_opcode_i inside {8'h00, 8'hA4} |=> !code_rd_req_o;
  endproperty
  a_no_req: assert property (p_no_req) else $error("stray table read");
  // all fields but acc kept
  property p_load_res;
    arch_we_o && op_q[3:0] == 4'h3 |->
      arch_o.acc == $past(code_rd_data_i) && arch_o[41:0] == snap_q[41:0];
  endproperty
  a_load_res: assert property (p_load_res) else $error("load result wrong");
  property p_prod_lat;
    tk && issue_opcode_i == 8'hA4 |=> !arch_we_o [*4] ##1 arch_we_o;
  endproperty
  a_prod_lat: assert property (p_prod_lat) else $error("product timing wrong");
  property p_prod_val;
    arch_we_o && op_q == 8'hA4 |-> {arch_o.aux, arch_o.acc} == prod_q
      && arch_o[33:2] == snap_q[33:2];
  endproperty
  a_prod_val: assert property (p_prod_val) else $error("product value wrong");
  property p_prod_flag;
    arch_we_o && op_q == 8'hA4 |->
      !arch_o.carry && arch_o.product_exceeds_byte_flag == (prod_q > 16'h00ff);
  endproperty
  a_prod_flag: assert property (p_prod_flag) else $error("flags wrong");
  property p_unknown;
    tk && !(issue_opcode_i inside {8'h00, 8'h83, 8'h93, 8'hA4}) |-> unknown_op_o ##1 !busy_o;
  endproperty
  a_unknown: assert property (p_unknown) else $error("bad opcode taken");
  c_load: cover property (tk && issue_opcode_i == 8'h93);
  c_over: cover property (arch_we_o && arch_o.product_exceeds_byte_flag);
  c_idle: cover property (tk && issue_opcode_i == 8'h00);
endmodule

/* verif/clmne_code_mem.sv */
// program memory model answering table reads
`timescale 1ns/10ps
module clmne_code_mem (
  input  wire logic        ref_clk_i,
  input  wire logic        code_rd_req_i,
  input  wire logic [15:0] code_rd_addr_i,
  output logic      [7:0]  code_rd_data_o
);
  logic       hold_q;
  logic [7:0] last_q;
  always_ff @(posedge ref_clk_i) begin
    hold_q <= code_rd_req_i;
    last_q <= code_rd_data_o;
  end
  // inverse of the last output outside the one valid cycle, so a late sample shows
  assign code_rd_data_o = hold_q ? code_rd_addr_i[7:0] ^ code_rd_addr_i[15:8] ^ 8'h5a : ~last_q;
endmodule

/* verif/code_lookup_multiply_nop_exec_tb_top.sv */
// testbench top for the execution block
`timescale 1ns/10ps
module code_lookup_multiply_nop_exec_tb_top;
  logic                   ref_clk_i, nrst_i, issue_valid_i, issue_ready_o, unknown_op_o;
  logic                   code_rd_req_o, arch_we_o, busy_o;
  logic [7:0]             issue_opcode_i, code_rd_data_i;
  logic [15:0]            code_rd_addr_o;
  clmne_pkg::clmne_arch_s arch_i, arch_o;
  clmne_pkg::clmne_arch_s exq[$];
  int                     fail_count, checks, cyc;
  logic [7:0]             ops [4] = '{8'h00, 8'h83, 8'h93, 8'hA4};
  clmne_exec #(.MC_CLKS(1)) uut (.ref_clk_i, .nrst_i, .issue_valid_i, .issue_opcode_i,
    .arch_i, .issue_ready_o, .unknown_op_o, .code_rd_req_o, .code_rd_addr_o,
    .code_rd_data_i, .arch_o, .arch_we_o, .busy_o);
  clmne_code_mem m_mem (.ref_clk_i, .code_rd_req_i(code_rd_req_o),
    .code_rd_addr_i(code_rd_addr_o), .code_rd_data_o(code_rd_data_i));
  // ****
  // helpers
  // ****
  task automatic print_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [49:0] seen, input logic [49:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic clmne_pkg::clmne_arch_s expect_of(input logic [7:0] op,
      input clmne_pkg::clmne_arch_s a);
    logic [15:0] b;
    expect_of = a;
    expect_of.pc = a.pc + 16'h0001;
    b = ((op == 8'h83) ? expect_of.pc : a.data_pointer) + {8'h00, a.acc};
    if (op == 8'hA4) begin
      b = {8'h00, a.acc} * {8'h00, a.aux};
      {expect_of.aux, expect_of.acc} = b;
      expect_of.carry = 1'b0;
      expect_of.product_exceeds_byte_flag = b > 16'h00ff;
    end else if (op != 8'h00) expect_of.acc = b[7:0] ^ b[15:8] ^ 8'h5a;
  endfunction
  // valid stays up between calls; ready is stable by the falling edge
  task automatic issue(input logic [7:0] op, input clmne_pkg::clmne_arch_s a);
    issue_valid_i = 1'b1;
    issue_opcode_i = op;
    arch_i = a;
    #2;
    while (!issue_ready_o) @(negedge ref_clk_i);
    if (op inside {8'h00, 8'h83, 8'h93, 8'hA4}) exq.push_back(expect_of(op, a));
    else chk(50'(unknown_op_o), 50'h1);
    @(negedge ref_clk_i);
  endtask
  // ****
  // clock, monitor, timeout
  // ****
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(negedge ref_clk_i) begin
    if (nrst_i && arch_we_o === 1'b1) begin
      if (exq.size() == 0) chk(50'h0, 50'h1);
      else chk(arch_o, exq.pop_front());
    end
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    nrst_i = 1'b0;
    issue_valid_i = 1'b0;
    issue_opcode_i = 8'h00;
    arch_i = '0;
    void'($urandom(32'hafcc));
    repeat (20) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    issue(8'h83, {8'hff, 8'h00, 16'hffff, 16'h1234, 2'h3});
    issue(8'h93, {8'h05, 8'h77, 16'h0100, 16'h00fe, 2'h2});
    issue(8'hA4, {8'hff, 8'h01, 16'h0200, 16'h0000, 2'h3});
    issue(8'hA4, {8'h10, 8'h10, 16'h0300, 16'h0000, 2'h2});
    issue(8'h00, {8'h12, 8'h34, 16'hffff, 16'h5678, 2'h3});
    issue(8'h01, {8'h00, 8'h00, 16'h0000, 16'h0000, 2'h0});
    repeat (60) issue(ops[$urandom % 4], 50'({$urandom, $urandom}));
    issue_valid_i = 1'b0;
    repeat (10) @(negedge ref_clk_i);
    chk(50'(exq.size()), 50'h0);
    print_verdict();
  end
endmodule
bind clmne_exec clmne_exec_checker #(.MC_CLKS(MC_CLKS)) u_chk (.ref_clk_i, .nrst_i,
  .issue_valid_i, .issue_opcode_i, .arch_i, .issue_ready_o, .unknown_op_o, .code_rd_req_o,
  .code_rd_addr_o, .code_rd_data_i, .arch_o, .arch_we_o, .busy_o);
